// ===== verilog/dmem_map.svh
/*
 * Offsets, field positions and reset values of the data-memory
 * addressing unit.
 * Assumes it is included by bare name after the types package.
 */
`ifndef DMEM_MAP_SVH
`define DMEM_MAP_SVH

// ****************************************************************
// Register indices in the data space (byte address = 4 * index)
// ****************************************************************
`define OFS_IND0 8'h00
`define OFS_PTR0 8'h01
`define OFS_PC_LO 8'h02
`define OFS_PC_HOLD 8'h03
`define OFS_STATUS 8'h04
`define OFS_IND1 8'h08
`define OFS_PTR1 8'h09
`define OFS_TPL 8'h0D
`define OFS_TPH 8'h0E
`define OFS_BANK 8'h0F
`define SFR_BANKED_TOP 5'h02
`define GPR_LO 8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define ZERO_BIT 4
`define P1_MODE_HI 3
`define P1_MODE_LO 2
`define P0_MODE_HI 1
`define P0_MODE_LO 0
`define GPR_BANK_BIT 4
`define SFR_BANK_HI 1

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_STATUS 8'h0A
`define RST_PTR 8'h00
`define RST_BYTE 8'h00
`define RST_PC 16'h0000

`endif

// ===== verilog/dmem_pkg.sv
/*
 * Types shared by the data-memory addressing unit.
 * Assumes nothing of its surroundings.
 */
package dmem_pkg;

    // Pointer update after each indirect access; code 3 also holds
    typedef enum logic [1:0] {PTR_DEC, PTR_INC, PTR_HOLD} ptr_mode_t;

endpackage

// ===== verilog/ptr_unit.sv
/*
 * One indirect pointer with post-access step control.
 * Assumes load and step come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "dmem_map.svh"

module ptr_unit
    import dmem_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input logic clock,
    input logic rst,
    input logic load,
    input logic [WIDTH-1:0] load_data,
    input logic step,
    input logic [1:0] mode,
    output logic [WIDTH-1:0] ptr
);

    logic [WIDTH-1:0] ptr_r;
    logic [WIDTH-1:0] ptr_nxt;

    // ************************************************************
    // Next pointer value
    // ************************************************************
    // A direct write beats the step of the same cycle
    always_comb begin
        ptr_nxt = ptr_r;
        if (load) begin
            ptr_nxt = load_data;
        end else if (step) begin
            case (ptr_mode_t'(mode))
                PTR_DEC: ptr_nxt = ptr_r - 1'b1;
                PTR_INC: ptr_nxt = ptr_r + 1'b1;
                default: ptr_nxt = ptr_r;
            endcase
        end
    end

    // Pointer storage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ptr_r <= WIDTH'(`RST_PTR);
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    assign ptr = ptr_r;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    ptr_inc_a: assert property (step && !load && mode == 2'h1 |=> ptr_r == $past(ptr_r) + 1'b1)
        else $error("pointer increment wrong");
    ptr_dec_a: assert property (step && !load && mode == 2'h0 |=> ptr_r == $past(ptr_r) - 1'b1)
        else $error("pointer decrement wrong");
    ptr_hold_a: assert property (!load && (!step || mode[1]) |=> $stable(ptr_r))
        else $error("pointer moved while holding");

endmodule

// ===== verilog/dmem_addressing.sv
/*
 * Data-memory addressing unit of an 8-bit core: banked register map,
 * two indirect channels, table pointer and latch, program counter.
 * Assumes an AHB-Lite master on the same clock and core strobes
 * (fetch, skip, load, table load) that are one-cycle pulses.
 */
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "dmem_map.svh"

module dmem_addressing
    import dmem_pkg::*;
#(
    parameter int GPR_DEPTH = 512,
    parameter int SFR_DEPTH = 32
)
(
    input logic clock,
    input logic rst,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input logic fetch,
    input logic skip,
    input logic load_en,
    input logic [15:0] load_addr,
    input logic tbl_load,
    input logic [15:0] tbl_word,
    output logic [15:0] pc_out,
    output logic forced_nop,
    output logic [15:0] table_address,
    output logic [15:0] table_holding_latch
);

    // ************************************************************
    // Bus address phase
    // ************************************************************
    logic [7:0] dp_addr_r;
    logic dp_ok_r;
    logic wr_ph_r;
    logic rd_ph_r;
    logic hreadyout_r;
    logic hresp_r;
    logic [7:0] hrdata_r;
    wire ap_take = hsel & htrans[1] & hready;
    wire ap_ok = (haddr[31:10] == 22'h000000);

    // Only whole words are used; hsize is accepted but not decoded
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dp_addr_r <= 8'h00;
            dp_ok_r <= 1'b0;
            wr_ph_r <= 1'b0;
            rd_ph_r <= 1'b0;
        end else begin
            wr_ph_r <= ap_take & hwrite;
            rd_ph_r <= ap_take & ~hwrite;
            if (ap_take) begin
                dp_addr_r <= haddr[9:2];
                dp_ok_r <= ap_ok;
            end
        end
    end

    // Reads take one wait state so that read data leaves a flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hreadyout_r <= ~(ap_take & ~hwrite);
            hresp_r <= 1'b0;
        end
    end

    // ************************************************************
    // Access decode
    // ************************************************************
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [7:0] status_r;
    logic [7:0] bank_r;
    logic [7:0] pc_hold_r;
    logic [15:0] pc_r;
    logic [7:0] tpl_r;
    logic [7:0] tph_r;

    // The indirect locations only redirect; they hold nothing
    wire acc_v = (wr_ph_r | rd_ph_r) & dp_ok_r;
    wire ind0 = (dp_addr_r == `OFS_IND0);
    wire ind1 = (dp_addr_r == `OFS_IND1);
    wire [7:0] eff = ind0 ? ptr0 : (ind1 ? ptr1 : dp_addr_r);
    wire eff_ind = (eff == `OFS_IND0) | (eff == `OFS_IND1);
    wire nul = (ind0 | ind1) & eff_ind;
    wire [7:0] wdata = hwdata[7:0];
    wire we = acc_v & wr_ph_r & ~nul;
    wire re = acc_v & rd_ph_r;

    // Target selection on the effective address
    wire hit_ptr0 = (eff == `OFS_PTR0);
    wire hit_ptr1 = (eff == `OFS_PTR1);
    wire hit_pc_lo = (eff == `OFS_PC_LO);
    wire hit_pc_hold = (eff == `OFS_PC_HOLD);
    wire hit_st = (eff == `OFS_STATUS);
    wire hit_tpl = (eff == `OFS_TPL);
    wire hit_tph = (eff == `OFS_TPH);
    wire hit_bank = (eff == `OFS_BANK);
    wire hit_sfr = (eff[7:3] == `SFR_BANKED_TOP);
    wire hit_gpr = (eff >= `GPR_LO);

    // Bank select applies whether the access was direct or indirect
    wire [4:0] sfr_idx = {bank_r[`SFR_BANK_HI:0], eff[2:0]};
    wire [8:0] gpr_idx = {bank_r[`GPR_BANK_BIT], eff};
    wire [4:0] misc_idx = eff[4:0];

    // ************************************************************
    // Storage arrays
    // ************************************************************
    // Banked specials, unbanked leftovers and general memory; no reset
    logic [7:0] sfr_mem [0:SFR_DEPTH-1];
    logic [7:0] misc_mem [0:31];
    logic [7:0] gpr_mem [0:GPR_DEPTH-1];
    wire hit_misc = ~(hit_ptr0 | hit_ptr1 | hit_pc_lo | hit_pc_hold | hit_st |
                      hit_tpl | hit_tph | hit_bank | hit_sfr | hit_gpr | eff_ind);

    always_ff @(posedge clock) begin
        if (we & hit_sfr) begin
            sfr_mem[sfr_idx] <= wdata;
        end
        if (we & hit_gpr) begin
            gpr_mem[gpr_idx] <= wdata;
        end
        if (we & hit_misc) begin
            misc_mem[misc_idx] <= wdata;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    wire [7:0] rd_val =
        hit_ptr0 ? ptr0 :
        hit_ptr1 ? ptr1 :
        hit_pc_lo ? pc_r[7:0] :
        hit_pc_hold ? pc_hold_r :
        hit_st ? status_r :
        hit_tpl ? tpl_r :
        hit_tph ? tph_r :
        hit_bank ? bank_r :
        hit_sfr ? sfr_mem[sfr_idx] :
        hit_gpr ? gpr_mem[gpr_idx] :
        hit_misc ? misc_mem[misc_idx] : 8'h00;

    // Self reference, zero pointer and unmapped words read as zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hrdata_r <= 8'h00;
        end else if (rd_ph_r) begin
            hrdata_r <= (dp_ok_r & ~nul) ? rd_val : 8'h00;
        end
    end

    assign hrdata = {24'h000000, hrdata_r};
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;

    // ************************************************************
    // Indirect pointers
    // ************************************************************
    // Each pointer steps after every access through its channel
    ptr_unit #(.WIDTH(8)) u_ptr0 (
        .clock(clock),
        .rst(rst),
        .load(we & hit_ptr0),
        .load_data(wdata),
        .step(acc_v & ind0),
        .mode(status_r[`P0_MODE_HI:`P0_MODE_LO]),
        .ptr(ptr0)
    );

    ptr_unit #(.WIDTH(8)) u_ptr1 (
        .clock(clock),
        .rst(rst),
        .load(we & hit_ptr1),
        .load_data(wdata),
        .step(acc_v & ind1),
        .mode(status_r[`P1_MODE_HI:`P1_MODE_LO]),
        .ptr(ptr1)
    );

    // ************************************************************
    // Status and bank select
    // ************************************************************
    logic [7:0] status_nxt;

    // Stepping never reaches here; only a null read sets zero, and it
    // wins over a software write in the same cycle
    always_comb begin
        status_nxt = status_r;
        if (we & hit_st) begin
            status_nxt = wdata;
        end
        if (re & nul) begin
            status_nxt[`ZERO_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_r <= `RST_STATUS;
            bank_r <= `RST_BYTE;
        end else begin
            status_r <= status_nxt;
            if (we & hit_bank) begin
                bank_r <= wdata;
            end
        end
    end

    // ************************************************************
    // Table pointer and table latch
    // ************************************************************
    logic [15:0] tlat_r;

    // The latch has no address; only the table transfer path fills it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tpl_r <= `RST_BYTE;
            tph_r <= `RST_BYTE;
            tlat_r <= 16'h0000;
        end else begin
            if (we & hit_tpl) begin
                tpl_r <= wdata;
            end
            if (we & hit_tph) begin
                tph_r <= wdata;
            end
            if (tbl_load) begin
                tlat_r <= tbl_word;
            end
        end
    end

    assign table_address = {tph_r, tpl_r};
    assign table_holding_latch = tlat_r;

    // ************************************************************
    // Program counter
    // ************************************************************
    logic [15:0] pc_nxt;
    logic skip_pend_r;
    logic forced_nop_r;
    wire we_pc_lo = we & hit_pc_lo;

    // A core load or a low-byte write replaces the fetch increment
    always_comb begin
        pc_nxt = pc_r;
        if (load_en) begin
            pc_nxt = load_addr;
        end else if (we_pc_lo) begin
            pc_nxt = {pc_hold_r, wdata};
        end else if (fetch) begin
            pc_nxt = pc_r + 16'h0001;
        end
    end

    // Reading the low byte copies the live high byte into the latch
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pc_r <= `RST_PC;
            pc_hold_r <= `RST_BYTE;
        end else begin
            pc_r <= pc_nxt;
            if (we & hit_pc_hold) begin
                pc_hold_r <= wdata;
            end else if (re & hit_pc_lo & ~nul) begin
                pc_hold_r <= pc_r[15:8];
            end
        end
    end

    // A skip turns the next fetched instruction into a bubble; the
    // counter still advances past it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            skip_pend_r <= 1'b0;
            forced_nop_r <= 1'b0;
        end else begin
            skip_pend_r <= skip | (skip_pend_r & ~fetch);
            if (fetch) begin
                forced_nop_r <= skip_pend_r;
            end
        end
    end

    assign pc_out = pc_r;
    assign forced_nop = forced_nop_r;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    null_read_a: assert property (re && nul |=> hrdata_r == 8'h00 && status_r[`ZERO_BIT])
        else $error("null read not zero");
    zero_ptr_a: assert property (re && ind0 && ptr0 == 8'h00 |=> status_r[`ZERO_BIT])
        else $error("zero pointer read missed flag");
    null_write_a: assert property (acc_v && wr_ph_r && nul |=> status_r == $past(status_r))
        else $error("null write changed status");
    step_flags_a: assert property (re && (ind0 || ind1) && !nul && !hit_st |=> $stable(status_r))
        else $error("pointer step touched status");
    gpr_bank_a: assert property (re && !nul && hit_gpr |=> hrdata_r == $past(gpr_mem[gpr_idx]))
        else $error("banked read wrong");
    pc_lo_load_a: assert property (we_pc_lo && !load_en |=> pc_r == {$past(pc_hold_r), $past(wdata)})
        else $error("low byte write did not load high");
    pc_inc_a: assert property (fetch && !load_en && !we_pc_lo |=> pc_r == $past(pc_r) + 16'h0001)
        else $error("counter did not increment");
    skip_pend_a: assert property (skip |=> skip_pend_r)
        else $error("skip not remembered");
    skip_nop_a: assert property (fetch && skip_pend_r |=> forced_nop_r)
        else $error("skip not turned into no-op");
    nop_clear_a: assert property (fetch && !skip_pend_r |=> !forced_nop_r)
        else $error("no-op left standing");
    read_wait_a: assert property (ap_take && !hwrite |=> !hreadyout_r ##1 hreadyout_r)
        else $error("read answer timing wrong");

endmodule

// ===== verification/core_model.sv
/*
 * Behavioural model of the core's execution side: turns bench commands
 * into one-cycle fetch, skip, load and table strobes.
 * Assumes commands change just after a rising edge of clock.
 */
`timescale 1ns/1ps

module core_model
(
    input logic clock,
    input logic rst,
    input logic [2:0] cmd,
    input logic [15:0] arg,
    output logic fetch,
    output logic skip,
    output logic load_en,
    output logic [15:0] load_addr,
    output logic tbl_load,
    output logic [15:0] tbl_word
);
    // One strobe per command; idle data lines invert so stale values never pass
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fetch <= 1'h0;
            skip <= 1'h0;
            load_en <= 1'h0;
            tbl_load <= 1'h0;
            load_addr <= 16'h0000;
            tbl_word <= 16'h0000;
        end else begin
            fetch <= (cmd == 3'h1);
            skip <= (cmd == 3'h2);
            load_en <= (cmd == 3'h3);
            tbl_load <= (cmd == 3'h4);
            load_addr <= (cmd == 3'h3) ? arg : ~load_addr;
            tbl_word <= (cmd == 3'h4) ? arg : ~tbl_word;
        end
    end
endmodule

// ===== verification/tb_dmem_addressing.sv
/*
 * Self-checking bench for the data-memory addressing unit.
 * Assumes the bench is the only bus master and core_model the core.
 */
`timescale 1ns/1ps
`include "dmem_map.svh"

module tb_dmem_addressing
    import dmem_pkg::*;
;
    typedef struct {logic [7:0] idx; logic [7:0] wr; logic [7:0] exp;} row_t;
    logic clock, rst, hsel, hwrite, hreadyout, hresp, fetch, skip, load_en, tbl_load, forced_nop, rdy_s;
    logic [31:0] haddr, hwdata, hrdata, rd_s, rd_v;
    logic [1:0] htrans;
    logic [2:0] hsize, cmd;
    logic [15:0] arg, load_addr, tbl_word, pc_out, table_address, table_holding_latch;
    logic [7:0] st, st2;
    int mismatches, check_count;
    row_t rows[9] = '{'{`OFS_PTR0, 8'h55, 8'h55}, '{`OFS_PTR1, 8'hAA, 8'hAA}, '{`OFS_PC_HOLD, 8'h12, 8'h12},
        '{`OFS_TPL, 8'h34, 8'h34}, '{`OFS_TPH, 8'h12, 8'h12}, '{8'h05, 8'h3C, 8'h3C},
        '{8'h18, 8'h6B, 8'h6B}, '{8'h20, 8'h5A, 8'h5A}, '{8'h10, 8'hB0, 8'hB0}};

    dmem_addressing dmem_addressing_i (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fetch(fetch), .skip(skip), .load_en(load_en),
        .load_addr(load_addr), .tbl_load(tbl_load), .tbl_word(tbl_word), .pc_out(pc_out),
        .forced_nop(forced_nop), .table_address(table_address), .table_holding_latch(table_holding_latch));
    core_model core_model_i (.clock(clock), .rst(rst), .cmd(cmd), .arg(arg), .fetch(fetch), .skip(skip),
        .load_en(load_en), .load_addr(load_addr), .tbl_load(tbl_load), .tbl_word(tbl_word));

    // 40 MHz clock
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    // Sample ready and read data mid-cycle, so the next edge sees settled values
    always @(negedge clock) begin
        rdy_s = hreadyout;
        rd_s = hrdata;
    end

    // ****************************************************************
    // Bus and core tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_rdy();
        do @(posedge clock); while (rdy_s !== 1'h1);
    endtask

    task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
        @(posedge clock);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        wait_rdy();
        q = rd_s;
        hsel <= 1'h0;
        // Let the closing edge's updates settle before anyone looks
        #1;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer({22'h000000, idx, 2'h0}, 1'h1, d, rd_v);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
        xfer({22'h000000, idx, 2'h0}, 1'h0, 8'h00, rd_v);
        chk(what, {24'h000000, exp}, rd_v);
    endtask

    // Strobe reaches the design one edge after the command; result lands one edge later
    task automatic core(input logic [2:0] op, input logic [15:0] a);
        @(posedge clock);
        cmd <= op;
        arg <= a;
        @(posedge clock);
        cmd <= 3'h0;
        @(posedge clock);
        #1;
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog sized far above the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        report_and_stop();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata, cmd, arg} = {1'h1, 68'h0, 3'h0, 16'h0000};
        hsize = 3'h2;
        mismatches = 0;
        check_count = 0;
        st = {4'h0, PTR_DEC, PTR_INC};
        st2 = {4'h0, PTR_HOLD, PTR_INC};
        // Reset spans five rising edges; the fifth releases it
        repeat (4) @(posedge clock);
        #1;
        chk("pc_out", 32'h0, {pc_out, table_address});
        chk("table latch", 32'h2, {table_holding_latch, forced_nop, hreadyout, hresp});
        @(posedge clock);
        rst <= 1'h0;
        rdc(`OFS_STATUS, 8'h0A, "arith_status");
        rdc(`OFS_PTR0, 8'h00, "pointer_0");
        rdc(`OFS_BANK, 8'h00, "bank_select");
        for (int i = 0; i < 9; i++) begin
            wr(rows[i].idx, rows[i].wr);
            rdc(rows[i].idx, rows[i].exp, "row");
        end
        chk("table_address", 32'h1234, {16'h0000, table_address});
        core(3'h4, 16'hBEEF);
        chk("table latch", 32'hBEEF, {16'h0000, table_holding_latch});
        // Unmapped space ignores writes and reads as zero
        xfer(32'h00000400, 1'h1, 8'hEE, rd_v);
        xfer(32'h00000400, 1'h0, 8'h00, rd_v);
        chk("unmapped", 32'h0, rd_v);
        // Banked specials and general memory
        wr(`OFS_BANK, 8'h01);
        wr(8'h10, 8'hA1);
        rdc(8'h18, 8'h6B, "unbanked special");
        wr(`OFS_BANK, 8'h10);
        wr(8'h20, 8'hC1);
        wr(`OFS_BANK, 8'h00);
        rdc(8'h10, 8'hB0, "special bank 0");
        rdc(8'h20, 8'h5A, "general bank 0");
        // Indirect channels: increment, decrement, wrap, banked target
        wr(`OFS_STATUS, st);
        wr(`OFS_PTR0, 8'h21);
        wr(`OFS_IND0, 8'h77);
        rdc(`OFS_PTR0, 8'h22, "pointer_0 step");
        rdc(8'h21, 8'h77, "indirect target");
        wr(`OFS_BANK, 8'h11);
        wr(`OFS_PTR0, 8'h20);
        rdc(`OFS_IND0, 8'hC1, "banked indirect");
        rdc(8'h10, 8'hA1, "special bank 1");
        wr(`OFS_BANK, 8'h00);
        wr(`OFS_PTR1, 8'h20);
        rdc(`OFS_IND1, 8'h5A, "indirect read");
        rdc(`OFS_PTR1, 8'h1F, "pointer_1 step");
        wr(`OFS_PTR0, 8'hFF);
        wr(`OFS_IND0, 8'h99);
        rdc(`OFS_PTR0, 8'h00, "pointer wrap");
        rdc(`OFS_STATUS, st, "zero flag kept");
        rdc(8'hFF, 8'h99, "indirect write");
        // Null pointer and self reference
        rdc(`OFS_IND0, 8'h00, "null read");
        rdc(`OFS_STATUS, st | 8'h10, "null zero flag");
        wr(`OFS_STATUS, st);
        wr(`OFS_PTR0, 8'h00);
        wr(`OFS_IND0, 8'h33);
        rdc(`OFS_STATUS, st, "null write");
        wr(`OFS_STATUS, st2);
        wr(`OFS_PTR1, 8'h08);
        wr(`OFS_IND1, 8'h55);
        rdc(`OFS_STATUS, st2, "self write");
        rdc(`OFS_IND1, 8'h00, "self read");
        rdc(`OFS_STATUS, st2 | 8'h10, "self zero flag");
        rdc(`OFS_PTR1, 8'h08, "pointer hold");
        wr(`OFS_STATUS, 8'h0C);
        wr(`OFS_PTR1, 8'h20);
        rdc(`OFS_IND1, 8'h5A, "code 3 read");
        rdc(`OFS_PTR1, 8'h20, "code 3 hold");
        // Program counter: fetch, load, low-byte write, skip
        core(3'h1, 16'h0000);
        core(3'h1, 16'h0000);
        chk("pc fetch", 32'h2, {16'h0000, pc_out});
        core(3'h3, 16'h1FFF);
        chk("pc load", 32'h1FFF, {16'h0000, pc_out});
        core(3'h1, 16'h0000);
        chk("pc carry", 32'h2000, {16'h0000, pc_out});
        wr(`OFS_PC_HOLD, 8'h12);
        wr(`OFS_PC_LO, 8'h34);
        chk("pc low write", 32'h1234, {16'h0000, pc_out});
        wr(`OFS_PC_HOLD, 8'h77);
        rdc(`OFS_PC_LO, 8'h34, "pc_low_byte");
        rdc(`OFS_PC_HOLD, 8'h12, "pc_high_holding");
        core(3'h2, 16'h0000);
        core(3'h1, 16'h0000);
        chk("skip", 32'h11235, {15'h0000, forced_nop, pc_out});
        core(3'h1, 16'h0000);
        chk("after skip", 32'h01236, {15'h0000, forced_nop, pc_out});
        core(3'h3, 16'hFFFF);
        core(3'h1, 16'h0000);
        chk("pc wrap", 32'h0, {16'h0000, pc_out});
        // Second reset in mid-run
        core(3'h1, 16'h0000);
        rst <= 1'h1;
        @(posedge clock);
        rst <= 1'h0;
        #1;
        chk("pc reset", 32'h0, {16'h0000, pc_out});
        rdc(`OFS_STATUS, 8'h0A, "status reset");
        report_and_stop();
    end
endmodule
